// ===== rtl/aacrb_top.sv
`timescale 1ns/1ps
// Overview of operation
// R01: Read-only identity at address zero: part code high nibble, revision low nibble.
// R02: Global control resets zero; bit 7 clear uses straps, set uses register fields.
// R03: Ratio bit set gives 384x, divide by 1.5; clear passes crystal clock.
// R04: Ratio plus divider: 000=1,100=1.5,001/010=2,101/110=3,011=4,111 reserved.
// R05: Format field bits 3:2: left-justified, I2S, TDM, reserved.
// R06: Speed field bits 1:0: single, double, quad master, or slave.
// R07: Channel overflow drives its status bit low and pulls open-drain pin low.
// R08: Overflow bits stay asserted until a status read returns then clears them.
// R09: Mask bit low stops that channel affecting the pin; mask resets all ones.
// R10: Eight DC filter control bits, reset zero with every filter enabled.
// R11: Power bit 5 set powers down the bandgap reference.
// R12: Power bit 4 set stops oscillator and blocks external master clock.
// R13: Each set pair bit gates that pair's clocks and zeros its data.
// R14: Power register resets zero; top two bits reserved.
// R15: Each set silence bit forces that channel's data to zeros; reset zero.
// R16: Each set low tristate bit floats its serial output; reset zero.
// R17: Filter bit high freezes offset estimate; low keeps estimate updating. Code ignores the bits and keeps filters updating while global bit 7 is clear.
// R18: Eight-bit pointer selects registers; auto-advance bit steps it per byte.
// R19: Addresses above 0Ah are reserved.
// R20: Reserved registers and bits read zero and ignore writes.
// R21: An overflow during a status read stays flagged after the read.
`include "aacrb_defs.svh"

module aacrb_top
    import aacrb_pkg::*;
(
    input  wire logic             SYS_CLK,
    input  wire logic             RST,
    input  wire logic             CLK_EN,
    // Byte stream from the control-port engine
    input  wire aacrb_cmd_type    CMD,
    output logic [7:0]            RDATA,
    output logic                  RVALID,
    // Overflow detect pulses from the channels
    input  wire logic [7:0]       OVF_EVENT,
    // Strap pins for stand-alone operation
    input  wire aacrb_global_type STRAP,
    // Configuration to the converter core
    output aacrb_config_type      CONFIG,
    output logic [7:0]            DC_FREEZE,
    output logic                  BANDGAP_OFF,
    output logic                  OSC_OFF,
    output logic                  MCLK_BLOCK,
    output logic [3:0]            PAIR_CLK_OFF,
    output logic [7:0]            DATA_ZERO,
    output logic [3:0]            SERIAL_AUDIO_OUT_OE,
    // Open-drain overflow pin: output low while enabled
    output logic                  OVF_PIN_O,
    output logic                  OVF_PIN_OE
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------

    // Composite crystal division
    function automatic aacrb_div_type div_decode(input logic ratio, input logic [1:0] mdiv);
        logic [2:0] code;
        code = {ratio, mdiv};
        case (code)
            3'h0:    div_decode = AACRB_DIV_1;       // see R04
            3'h4:    div_decode = AACRB_DIV_1P5;     // see R03
            3'h1:    div_decode = AACRB_DIV_2;
            3'h2:    div_decode = AACRB_DIV_2;
            3'h5:    div_decode = AACRB_DIV_3;
            3'h6:    div_decode = AACRB_DIV_3;
            3'h3:    div_decode = AACRB_DIV_4;
            default: div_decode = AACRB_DIV_RSVD;
        endcase
    endfunction

    // Address hits an implemented register; holes and space above the map miss
    function automatic logic addr_valid(input logic [7:0] adr);
        logic in_range;
        logic is_hole;
        in_range   = (adr <= `AACRB_ADR_LAST);                                         // see R19
        is_hole    = (adr == `AACRB_ADR_RSVD_A) || (adr == `AACRB_ADR_RSVD_B) || (adr == `AACRB_ADR_RSVD_C);
        addr_valid = in_range && !is_hole;                                             // see R20
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [7:0]       ovf_meta_q, ovf_meta_d;
    logic [7:0]       ovf_sync_q, ovf_sync_d;
    aacrb_global_type strap_meta_q, strap_meta_d;
    aacrb_global_type strap_sync_q, strap_sync_d;

    // Two-flop chain next values
    // Only the second stage feeds logic; the first may still be settling
    always_comb begin
        ovf_meta_d   = OVF_EVENT;
        ovf_sync_d   = ovf_meta_q;
        strap_meta_d = STRAP;
        strap_sync_d = strap_meta_q;
    end

    // Synchroniser flops
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ovf_meta_q   <= 8'h00;
            ovf_sync_q   <= 8'h00;
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end else if (CLK_EN) begin
            ovf_meta_q   <= ovf_meta_d;
            ovf_sync_q   <= ovf_sync_d;
            strap_meta_q <= strap_meta_d;
            strap_sync_q <= strap_sync_d;
        end
    end

    // ----------------------------------------------------------------
    // Pointer and access state
    // ----------------------------------------------------------------
    logic [7:0]      ptr_q, ptr_d;
    aacrb_state_type state_q, state_d;

    wire logic       auto_adv = ptr_q[`AACRB_PTR_POINTER_AUTOADVANCE_BIT];
    wire logic [7:0] cur_adr  = ptr_q & `AACRB_PTR_ADDR_MASK;

    // Pointer load and auto-advance
    // Advance wraps inside seven address bits and keeps the mode bit
    always_comb begin
        ptr_d   = ptr_q;
        state_d = AACRB_ST_IDLE;
        if (CMD.ptr_load) begin
            ptr_d = CMD.ptr_value;                           // see R18
        end else if (CMD.wr || CMD.rd) begin
            state_d = CMD.wr ? AACRB_ST_WRITE : AACRB_ST_READ;
            if (auto_adv) begin
                ptr_d = {ptr_q[7], 7'((cur_adr + 8'h01) & `AACRB_PTR_ADDR_MASK)}; // see R18
            end
        end
    end

    // Pointer and phase flops
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ptr_q   <= 8'h00;
            state_q <= AACRB_ST_IDLE;
        end else if (CLK_EN) begin
            ptr_q   <= ptr_d;
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    aacrb_global_type global_q, global_d;
    logic [7:0]       ovf_stat_q, ovf_stat_d;
    logic [7:0]       ovf_mask_q, ovf_mask_d;
    logic [7:0]       dc_filt_q, dc_filt_d;
    logic [7:0]       power_q, power_d;
    logic [7:0]       silence_q, silence_d;
    logic [7:0]       tristate_q, tristate_d;

    // A pointer load cancels an access in the same cycle; write beats read
    wire logic        do_wr  = CMD.wr && !CMD.ptr_load;
    wire logic        do_rd  = CMD.rd && !CMD.ptr_load && !CMD.wr;
    wire logic        adr_ok = addr_valid(cur_adr);

    // Writes to the control registers; reserved space keeps nothing
    always_comb begin
        global_d   = global_q;
        ovf_mask_d = ovf_mask_q;
        dc_filt_d  = dc_filt_q;
        power_d    = power_q;
        silence_d  = silence_q;
        tristate_d = tristate_q;
        if (do_wr && adr_ok) begin
            case (cur_adr)
                `AACRB_ADR_GLOBAL:   global_d   = aacrb_global_type'(CMD.wdata);
                `AACRB_ADR_OVF_MASK: ovf_mask_d = CMD.wdata;                        // see R09
                `AACRB_ADR_DC_FILT:  dc_filt_d  = CMD.wdata;                        // see R10
                `AACRB_ADR_POWER:    power_d    = CMD.wdata & `AACRB_POWER_MASK;    // see R14
                `AACRB_ADR_SILENCE:  silence_d  = CMD.wdata;                        // see R15
                `AACRB_ADR_TRISTATE: tristate_d = CMD.wdata & `AACRB_TRISTATE_MASK; // see R20
                default:             global_d   = global_q;                         // see R20
            endcase
        end
    end

    // Control register flops
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            global_q   <= aacrb_global_type'(`AACRB_RST_GLOBAL);                     // see R02
            ovf_mask_q <= `AACRB_RST_OVF_MASK;
            dc_filt_q  <= `AACRB_RST_DC_FILT;
            power_q    <= `AACRB_RST_POWER;
            silence_q  <= `AACRB_RST_SILENCE;
            tristate_q <= `AACRB_RST_TRISTATE;
        end else if (CLK_EN) begin
            global_q   <= global_d;
            ovf_mask_q <= ovf_mask_d;
            dc_filt_q  <= dc_filt_d;
            power_q    <= power_d;
            silence_q  <= silence_d;
            tristate_q <= tristate_d;
        end
    end

    // Sticky low-active overflow flags
    always_comb begin
        ovf_stat_d = ovf_stat_q;
        // Clear first, so an overflow in the same cycle still lands
        if (do_rd && (cur_adr == `AACRB_ADR_OVF_STAT)) begin
            ovf_stat_d = `AACRB_RST_OVF_STAT;                                        // see R08
        end
        ovf_stat_d = ovf_stat_d & ~ovf_sync_q;                                       // see R07, see R21
    end

    // Overflow flag flops
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ovf_stat_q <= `AACRB_RST_OVF_STAT;
        end else if (CLK_EN) begin
            ovf_stat_q <= ovf_stat_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;

    // Read multiplexer; reserved space reads zero
    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        if (do_rd) begin
            rvalid_d = 1'b1;
            case (cur_adr)
                `AACRB_ADR_IDENT:    rdata_d = {`AACRB_PART_ID, `AACRB_REVISION};  // see R01
                `AACRB_ADR_GLOBAL:   rdata_d = 8'(global_q);
                `AACRB_ADR_OVF_STAT: rdata_d = ovf_stat_q;                          // see R08
                `AACRB_ADR_OVF_MASK: rdata_d = ovf_mask_q;
                `AACRB_ADR_DC_FILT:  rdata_d = dc_filt_q;
                `AACRB_ADR_POWER:    rdata_d = power_q;
                `AACRB_ADR_SILENCE:  rdata_d = silence_q;
                `AACRB_ADR_TRISTATE: rdata_d = tristate_q;
                default:             rdata_d = 8'h00;                               // see R20
            endcase
        end
    end

    // Read answer flops
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (CLK_EN) begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ----------------------------------------------------------------
    // Configuration outputs
    // ----------------------------------------------------------------
    aacrb_config_type config_q, config_d;
    logic [7:0]       freeze_q, freeze_d;
    logic             bg_q, bg_d;
    logic             osc_q, osc_d;
    logic [3:0]       pair_q, pair_d;
    logic [7:0]       zero_q, zero_d;
    logic [3:0]       oe_q, oe_d;
    logic             ovf_oe_q, ovf_oe_d;
    aacrb_global_type src;
    logic [3:0]       pair_v;
    wire logic [7:0]  pair_chan;

    // Each pair owns two neighbouring channels
    for (genvar g = 0; g < 4; g++) begin : g_pair_chan
        assign pair_chan[2*g +: 2] = {2{power_q[g]}};
    end

    // Strap or register source, then derived controls
    always_comb begin
        src = global_q[`AACRB_GBL_REGISTER_CONTROL_ENABLE] ? global_q : strap_sync_q;                  // see R02
        pair_v = power_q[3:0];
        config_d.divider = div_decode(src.clock_ratio_select, src.crystal_divider_select); // see R03, see R04
        config_d.format  = src.serial_format_select;                                 // see R05
        config_d.speed   = src.speed_mode;                                           // see R06
        // Stand-alone keeps filters running
        freeze_d = global_q[`AACRB_GBL_REGISTER_CONTROL_ENABLE] ? dc_filt_q : 8'h00;                   // see R17
        bg_d     = power_q[`AACRB_PWR_BANDGAP];                                      // see R11
        osc_d    = power_q[`AACRB_PWR_OSC];                                          // see R12
        pair_d   = pair_v;                                                           // see R13
        zero_d   = silence_q | pair_chan;                                            // see R13, see R15
        oe_d     = ~tristate_q[3:0];                                                 // see R16
        // Pin pulls low for any unmasked flag, from the flag's next value
        ovf_oe_d = |(~ovf_stat_d & ovf_mask_q);                                      // see R07, see R09
    end

    // Derived control flops
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            config_q <= '0;
            freeze_q <= 8'h00;
            bg_q     <= 1'b0;
            osc_q    <= 1'b0;
            pair_q   <= 4'h0;
            zero_q   <= 8'h00;
            oe_q     <= 4'hf;
            ovf_oe_q <= 1'b0;
        end else if (CLK_EN) begin
            config_q <= config_d;
            freeze_q <= freeze_d;
            bg_q     <= bg_d;
            osc_q    <= osc_d;
            pair_q   <= pair_d;
            zero_q   <= zero_d;
            oe_q     <= oe_d;
            ovf_oe_q <= ovf_oe_d;
        end
    end

    // ----------------------------------------------------------------
    // Output drivers
    // ----------------------------------------------------------------

    // Every output except OVF_PIN_O comes straight from its flop; OVF_PIN_O is tied low
    assign RDATA        = rdata_q;
    assign RVALID       = rvalid_q;
    assign CONFIG       = config_q;
    assign DC_FREEZE    = freeze_q;
    assign BANDGAP_OFF  = bg_q;
    assign OSC_OFF      = osc_q;
    assign MCLK_BLOCK   = osc_q;
    assign PAIR_CLK_OFF = pair_q;
    assign DATA_ZERO    = zero_q;
    assign SERIAL_AUDIO_OUT_OE     = oe_q;
    assign OVF_PIN_O    = 1'b0;  // Open drain only pulls low
    assign OVF_PIN_OE   = ovf_oe_q;

endmodule // aacrb_top

// ===== rtl/aacrb_defs.svh
`ifndef AACRB_DEFS_SVH
`define AACRB_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AACRB_ADR_IDENT     8'h00
`define AACRB_ADR_GLOBAL    8'h01
`define AACRB_ADR_OVF_STAT  8'h02
`define AACRB_ADR_OVF_MASK  8'h03
`define AACRB_ADR_DC_FILT   8'h04
`define AACRB_ADR_POWER     8'h06
`define AACRB_ADR_SILENCE   8'h08
`define AACRB_ADR_TRISTATE  8'h0a
`define AACRB_ADR_LAST      8'h0a
`define AACRB_ADR_RSVD_A    8'h05
`define AACRB_ADR_RSVD_B    8'h07
`define AACRB_ADR_RSVD_C    8'h09

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AACRB_RST_GLOBAL    8'h00
`define AACRB_RST_OVF_STAT  8'hff
`define AACRB_RST_OVF_MASK  8'hff
`define AACRB_RST_DC_FILT   8'h00
`define AACRB_RST_POWER     8'h00
`define AACRB_RST_SILENCE   8'h00
`define AACRB_RST_TRISTATE  8'h00

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define AACRB_GBL_REGISTER_CONTROL_ENABLE     7
`define AACRB_GBL_RATIO     6
`define AACRB_PWR_BANDGAP   5
`define AACRB_PWR_OSC       4
`define AACRB_POWER_MASK    8'h3f
`define AACRB_TRISTATE_MASK 8'h0f
`define AACRB_PTR_POINTER_AUTOADVANCE_BIT  7
`define AACRB_PTR_ADDR_MASK 8'h7f

// ----------------------------------------------------------------
// Identity: arbitrary neutral values
// ----------------------------------------------------------------
`define AACRB_PART_ID       4'h5
`define AACRB_REVISION      4'h3

`endif

// ===== rtl/aacrb_pkg.sv
package aacrb_pkg;

    // Divider ratio seen by the clock tree
    typedef enum logic [2:0] {
        AACRB_DIV_1,
        AACRB_DIV_1P5,
        AACRB_DIV_2,
        AACRB_DIV_3,
        AACRB_DIV_4,
        AACRB_DIV_RSVD
    } aacrb_div_type;

    typedef enum logic [1:0] {
        AACRB_FMT_LEFT_JUST = 2'h0,
        AACRB_FMT_I2S       = 2'h1,
        AACRB_FMT_TDM       = 2'h2,
        AACRB_FMT_RSVD      = 2'h3
    } aacrb_fmt_type;

    typedef enum logic [1:0] {
        AACRB_SPD_SINGLE_MASTER = 2'h0,
        AACRB_SPD_DOUBLE_MASTER = 2'h1,
        AACRB_SPD_QUAD_MASTER   = 2'h2,
        AACRB_SPD_SLAVE         = 2'h3
    } aacrb_speed_type;

    // Global control register layout
    typedef struct packed {
        logic            register_control_enable;
        logic            clock_ratio_select;
        logic [1:0]      crystal_divider_select;
        aacrb_fmt_type   serial_format_select;
        aacrb_speed_type speed_mode;
    } aacrb_global_type;

    // Effective configuration driven to the converter core
    typedef struct packed {
        aacrb_div_type   divider;
        aacrb_fmt_type   format;
        aacrb_speed_type speed;
    } aacrb_config_type;

    // Register-access command from the control-port engine
    typedef struct packed {
        logic       ptr_load;
        logic [7:0] ptr_value;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } aacrb_cmd_type;

    // Access phase of the control-port byte stream
    typedef enum logic [1:0] {
        AACRB_ST_IDLE,
        AACRB_ST_WRITE,
        AACRB_ST_READ
    } aacrb_state_type;

endpackage

// ===== tb/aacrb_top_checker.sv
`timescale 1ns/1ps
module aacrb_top_checker
    import aacrb_pkg::*;
(
    input  wire logic          SYS_CLK,
    input  wire logic          RST,
    input  wire logic          CLK_EN,
    input  wire aacrb_cmd_type CMD,
    input  wire logic [7:0]    RDATA,
    input  wire logic          RVALID,
    input  wire logic [7:0]    OVF_EVENT,
    input  wire logic          OSC_OFF,
    input  wire logic          MCLK_BLOCK,
    input  wire logic [3:0]    PAIR_CLK_OFF,
    input  wire logic [7:0]    DATA_ZERO,
    input  wire logic          OVF_PIN_O,
    input  wire logic          OVF_PIN_OE
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    logic [7:0] pair_mask;

    // Channels owned by each powered-off pair
    assign pair_mask = {{2{PAIR_CLK_OFF[3]}}, {2{PAIR_CLK_OFF[2]}}, {2{PAIR_CLK_OFF[1]}}, {2{PAIR_CLK_OFF[0]}}};

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_read_answered: assert property ((CLK_EN && CMD.rd && !CMD.wr && !CMD.ptr_load) |=> RVALID)
        else $error("read request got no answer");
    a_answer_has_cause: assert property (RVALID |-> ($past(CLK_EN) ? ($past(CMD.rd) && !$past(CMD.wr)
        && !$past(CMD.ptr_load)) : $past(RVALID)))
        else $error("answer without a read request");
    a_rdata_held: assert property ($changed(RDATA) |-> RVALID)
        else $error("read data moved without an answer");
    a_clock_block_tied: assert property (MCLK_BLOCK == OSC_OFF)
        else $error("master clock block differs from oscillator off");
    a_pin_drive_low: assert property (OVF_PIN_O == 1'b0)
        else $error("overflow pin driven high");
    a_pin_needs_event: assert property ($rose(OVF_PIN_OE) |-> (|($past(OVF_EVENT, 3) | $past(OVF_EVENT, 4)
        | $past(OVF_EVENT, 5))))
        else $error("overflow pin pulled without an overflow");
    a_pair_zeroes: assert property ((DATA_ZERO & pair_mask) == pair_mask)
        else $error("powered-off pair not zeroed");
    a_frozen_state: assert property (!CLK_EN |=> $stable(RDATA) && $stable(OVF_PIN_OE) && $stable(DATA_ZERO))
        else $error("state moved while clock enable low");
endmodule // aacrb_top_checker

// ===== tb/aacrb_host.sv
`timescale 1ns/1ps
module aacrb_host
    import aacrb_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic [7:0] RDATA,
    input  wire logic       RVALID,
    output aacrb_cmd_type   CMD
);
    // Quiet bus at start
    initial CMD = '0;

    // One command for one cycle, then fields turned to junk
    task automatic send(input logic load, input logic wr, input logic rd, input logic [7:0] val);
        @(posedge SYS_CLK);
        CMD <= '{ptr_load: load, ptr_value: val, wr: wr, rd: rd, wdata: val};
        @(posedge SYS_CLK);
        CMD <= '{ptr_load: 1'b0, ptr_value: ~val, wr: 1'b0, rd: 1'b0, wdata: ~val};
    endtask

    // Read one byte, answer due one cycle after the request
    task automatic get(output logic [7:0] data, output logic ok);
        send(1'b0, 1'b0, 1'b1, 8'h00);
        #1;
        ok   = RVALID;
        data = RDATA;
    endtask
endmodule // aacrb_host

// ===== tb/aacrb_top_bench.sv
`timescale 1ns/1ps
`include "aacrb_defs.svh"
module aacrb_top_bench
    import aacrb_pkg::*;
;
    logic             sys_clk, rst, clk_en, rvalid, bandgap_off, osc_off, mclk_block, ovf_pin_o, ovf_pin_oe;
    aacrb_cmd_type    cmd;
    aacrb_global_type strap;
    aacrb_config_type config_w;
    logic [7:0]       rdata, ovf_event, dc_freeze, data_zero;
    logic [3:0]       pair_clk_off, serial_audio_out_oe;
    int               num_errors = 0;
    int               cmp_count  = 0;
    localparam logic [7:0] rst_tab [11] = '{{`AACRB_PART_ID, `AACRB_REVISION}, 8'h00, 8'hff, 8'hff, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam aacrb_div_type div_tab [8] = '{AACRB_DIV_1, AACRB_DIV_2, AACRB_DIV_2, AACRB_DIV_4,
        AACRB_DIV_1P5, AACRB_DIV_3, AACRB_DIV_3, AACRB_DIV_RSVD};

    // ------------------------------------------------------------
    // Design and host
    // ------------------------------------------------------------
    aacrb_top dut (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(clk_en), .CMD(cmd), .RDATA(rdata), .RVALID(rvalid),
        .OVF_EVENT(ovf_event), .STRAP(strap), .CONFIG(config_w), .DC_FREEZE(dc_freeze),
        .BANDGAP_OFF(bandgap_off), .OSC_OFF(osc_off), .MCLK_BLOCK(mclk_block), .PAIR_CLK_OFF(pair_clk_off),
        .DATA_ZERO(data_zero), .SERIAL_AUDIO_OUT_OE(serial_audio_out_oe), .OVF_PIN_O(ovf_pin_o), .OVF_PIN_OE(ovf_pin_oe));
    aacrb_host host (.SYS_CLK(sys_clk), .RDATA(rdata), .RVALID(rvalid), .CMD(cmd));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        host.send(1'b1, 1'b0, 1'b0, a);
        host.send(1'b0, 1'b1, 1'b0, d);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        host.send(1'b1, 1'b0, 1'b0, a);
        host.get(d, ok);
        check(8'(ok), 8'h01);
        check(d, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(input logic [7:0] ev);
        @(posedge sys_clk);
        ovf_event <= ev;
        @(posedge sys_clk);
        ovf_event <= 8'h00;
        settle(8);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic [7:0] d;
        logic       ok;
        host.send(1'b1, 1'b0, 1'b0, 8'h80);
        for (int a = 0; a < 11; a++) begin
            host.get(d, ok);
            check(d, rst_tab[a]);
        end
        check(8'(serial_audio_out_oe), 8'h0f);
        check(8'(ovf_pin_oe), 8'h00);
        check(8'(config_w), {1'b0, AACRB_DIV_3, AACRB_FMT_TDM, AACRB_SPD_SLAVE});
        check(dc_freeze, 8'h00);
    endtask
    task automatic t_global();
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            wreg(8'h01, {1'b1, k, k[1:0], ~k[1:0]});
            settle(3);
            check(8'(config_w), {1'b0, div_tab[k], k[1:0], ~k[1:0]});
            rreg(8'h01, {1'b1, k, k[1:0], ~k[1:0]});
        end
    endtask
    task automatic t_regs();
        host.send(1'b1, 1'b0, 1'b0, 8'h83);
        host.send(1'b0, 1'b1, 1'b0, 8'hfb);
        host.send(1'b0, 1'b1, 1'b0, 8'ha5);
        rreg(8'h03, 8'hfb);
        rreg(8'h04, 8'ha5);
        settle(3);
        check(dc_freeze, 8'ha5);
        wreg(8'h00, 8'hff);
        wreg(8'h05, 8'hff);
        wreg(8'h0b, 8'hff);
        rreg(8'h00, rst_tab[0]);
        rreg(8'h05, 8'h00);
        rreg(8'h0b, 8'h00);
    endtask
    task automatic t_power();
        wreg(8'h06, 8'hff);
        settle(3);
        check({bandgap_off, osc_off, mclk_block, 1'b0, pair_clk_off}, 8'hef);
        check(data_zero, 8'hff);
        rreg(8'h06, 8'h3f);
        wreg(8'h06, 8'h05);
        wreg(8'h08, 8'h80);
        wreg(8'h0a, 8'hff);
        settle(3);
        check({bandgap_off, osc_off, mclk_block, 1'b0, pair_clk_off}, 8'h05);
        check(data_zero, 8'hb3);
        check(8'(serial_audio_out_oe), 8'h00);
        rreg(8'h0a, 8'h0f);
        wreg(8'h06, 8'h00);
        wreg(8'h08, 8'h00);
        settle(3);
        check(data_zero, 8'h00);
    endtask
    task automatic t_freeze();
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wreg(8'h08, 8'hff);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rreg(8'h08, 8'h00);
    endtask
    task automatic t_overflow();
        logic [7:0] d;
        logic       ok;
        pulse(8'h04);
        check(8'(ovf_pin_oe), 8'h00);
        rreg(8'h02, 8'hfb);
        rreg(8'h02, 8'hff);
        wreg(8'h03, 8'hff);
        pulse(8'h08);
        check(8'(ovf_pin_oe), 8'h01);
        host.send(1'b1, 1'b0, 1'b0, 8'h02);
        host.get(d, ok);
        check(d, 8'hf7);
        host.get(d, ok);
        check(d, 8'hff);
        settle(3);
        check(8'(ovf_pin_oe), 8'h00);
        @(posedge sys_clk);
        ovf_event <= 8'h01;
        settle(8);
        rreg(8'h02, 8'hfe);
        rreg(8'h02, 8'hfe);
        @(posedge sys_clk);
        ovf_event <= 8'h00;
        settle(6);
        rreg(8'h02, 8'hfe);
        rreg(8'h02, 8'hff);
    endtask

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        rst       = 1'b1;
        clk_en    = 1'b1;
        ovf_event = 8'h00;
        strap     = '{1'b0, 1'b1, 2'b01, AACRB_FMT_TDM, AACRB_SPD_SLAVE};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_values();
        t_global();
        t_regs();
        t_power();
        t_freeze();
        t_overflow();
        give_verdict();
    end
endmodule // aacrb_top_bench

bind aacrb_top aacrb_top_checker u_checker (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN), .CMD(CMD),
    .RDATA(RDATA), .RVALID(RVALID), .OVF_EVENT(OVF_EVENT), .OSC_OFF(OSC_OFF), .MCLK_BLOCK(MCLK_BLOCK),
    .PAIR_CLK_OFF(PAIR_CLK_OFF), .DATA_ZERO(DATA_ZERO), .OVF_PIN_O(OVF_PIN_O), .OVF_PIN_OE(OVF_PIN_OE));
